/* File: isc_pkg.sv */
// constants for the instruction segment cache
package isc_pkg;
  localparam int SEG_CNT      = 4;
  localparam int SEG_BYTES    = 128;
  localparam int SUB_CNT      = 8;
  localparam int SUB_LW       = 4;
  localparam int TAG_W        = 22;
  localparam int ADDR_W       = 32;
  localparam int LW_ADDR_W    = 27;
  localparam int WORD_ADDR_W  = 28;
  localparam int DATA_W       = 32;
  localparam int INSN_W       = 16;
  localparam int TAG_LSB      = 10;
  localparam int SUB_LSB      = 7;
  localparam int LW_LSB       = 5;
  localparam int HALF_LSB     = 4;
  localparam int LW_TOTAL     = SEG_CNT * SUB_CNT * SUB_LW;
  localparam logic [1:0] LW_LAST = 2'h3;
endpackage

/* File: isc_cache.sv */
// instruction segment cache: lookup, lru, subsegment fill, flush
`timescale 1ns/100ps
`default_nettype none
module isc_cache
  import isc_pkg::*;
(
  // clock and reset
  input  wire logic                      REF_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic                      CLK_EN,
  // host control
  input  wire logic                      FLUSH,
  // fetch port from execution section
  input  wire logic                      FETCH_REQ,
  input  wire logic [isc_pkg::ADDR_W-1:0] FETCH_ADDR,
  output logic                           FETCH_ACK,
  output logic [isc_pkg::INSN_W-1:0]     FETCH_DATA,
  // memory controller port
  output logic                           MEM_REQ,
  output logic [isc_pkg::LW_ADDR_W-1:0]  MEM_ADDR,
  input  wire logic                      MEM_ACK,
  input  wire logic [isc_pkg::DATA_W-1:0] MEM_DATA
);
  import isc_pkg::*;

  // segment ids, subsegment and word selects are hard-wired to 4 x 8 x 4
  if (SEG_CNT != 4 || SUB_CNT != 8 || SUB_LW != 4 ||
      SEG_CNT * SEG_BYTES != 512 || TAG_W != ADDR_W - TAG_LSB) begin : geom_check
    $error("isc_cache: geometry must be 4 x 128 bytes");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DONE} isc_state_t;

  typedef struct packed {
    isc_state_t                       state;
    logic [SEG_CNT-1:0][TAG_W-1:0]    seg_tag;
    logic [SEG_CNT-1:0][SUB_CNT-1:0]  valid;
    logic [SEG_CNT-1:0][1:0]          lru;
    logic [1:0]                       fill_seg;
    logic [1:0]                       fill_lw;
    logic                             ack;
    logic [INSN_W-1:0]                data;
    logic                             mem_req;
    logic [LW_ADDR_W-1:0]             mem_addr;
  } isc_regs_t;

  isc_regs_t r;
  isc_regs_t next_r;

  // long-word array, written only during a fill
  logic [DATA_W-1:0] store [LW_TOTAL];

  // move the given segment to the top of the usage stack
  function automatic logic [SEG_CNT-1:0][1:0] lru_touch(
    input logic [SEG_CNT-1:0][1:0] s, input logic [1:0] id);
    logic [SEG_CNT-1:0][1:0] o;
    logic                    seen;
    o    = s;
    seen = 1'b0;
    for (int i = SEG_CNT - 1; i > 0; i--) begin
      if (s[i] == id) seen = 1'b1;
      if (seen) o[i] = s[i-1];
    end
    o[0] = id;
    return o;
  endfunction

  function automatic logic [6:0] lw_index(
    input logic [1:0] seg, input logic [2:0] sub, input logic [1:0] lw);
    return {seg, sub, lw};
  endfunction

  logic [TAG_W-1:0]   f_tag;
  logic [2:0]         f_sub;
  logic [1:0]         f_lw;
  logic               f_half;
  logic               tag_hit;
  logic [1:0]         hit_seg;
  logic               hit;
  logic [DATA_W-1:0]  hit_word;

  // low four bits ignored, whatever their value
  assign f_tag  = FETCH_ADDR[ADDR_W-1:TAG_LSB];
  assign f_sub  = FETCH_ADDR[TAG_LSB-1:SUB_LSB];
  assign f_lw   = FETCH_ADDR[SUB_LSB-1:LW_LSB];
  assign f_half = FETCH_ADDR[HALF_LSB];

  always_comb begin
    tag_hit = 1'b0;
    hit_seg = 2'h0;
    for (int i = 0; i < SEG_CNT; i++) begin
      if (r.seg_tag[i] == f_tag && !tag_hit) begin
        tag_hit = 1'b1;
        hit_seg = 2'(i);
      end
    end
  end

  assign hit      = tag_hit && r.valid[hit_seg][f_sub];
  assign hit_word = store[lw_index(hit_seg, f_sub, f_lw)];

  always_ff @(posedge REF_CLK) begin
    if (CLK_EN && r.state == ST_FILL && MEM_ACK) begin
      store[lw_index(r.fill_seg, f_sub, r.fill_lw)] <= MEM_DATA;
    end
  end

  // fetch address must stay stable while a request is pending
  always_comb begin
    next_r     = r;
    next_r.ack = 1'b0;
    case (r.state)
      ST_IDLE: begin
        if (FETCH_REQ && !FLUSH) begin
          if (hit) begin
            next_r.ack  = 1'b1;
            next_r.data = f_half ? hit_word[DATA_W-1:INSN_W] : hit_word[INSN_W-1:0];
            next_r.lru  = lru_touch(r.lru, hit_seg);
            next_r.state = ST_DONE;
          end else begin
            // reuse a matching segment, else take the bottom of the stack
            next_r.fill_seg = tag_hit ? hit_seg : r.lru[SEG_CNT-1];
            if (!tag_hit) begin
              next_r.seg_tag[r.lru[SEG_CNT-1]] = f_tag;
              next_r.valid[r.lru[SEG_CNT-1]]   = '0;
            end
            next_r.fill_lw  = 2'h0;
            next_r.mem_req  = 1'b1;
            next_r.mem_addr = {FETCH_ADDR[ADDR_W-1:SUB_LSB], 2'h0};
            next_r.state    = ST_FILL;
          end
        end
      end
      ST_FILL: begin
        if (MEM_ACK) begin
          if (r.fill_lw == LW_LAST) begin
            next_r.mem_req = 1'b0;
            next_r.valid[r.fill_seg][f_sub] = 1'b1;
            next_r.state = ST_IDLE;
          end else begin
            next_r.fill_lw  = r.fill_lw + 2'h1;
            next_r.mem_addr = r.mem_addr + LW_ADDR_W'(1);
          end
        end
      end
      ST_DONE: begin
        next_r.state = ST_IDLE;
      end
      default: next_r.state = ST_IDLE;
    endcase
    // flush clears all valid bits, tags and lru are kept; an in-flight fill is abandoned
    if (FLUSH) begin
      next_r.valid   = '0;
      next_r.mem_req = 1'b0;
      next_r.state   = ST_IDLE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      r.state    <= ST_IDLE;
      r.seg_tag  <= '0;
      r.valid    <= '0;
      r.lru      <= {2'h3, 2'h2, 2'h1, 2'h0};
      r.fill_seg <= 2'h0;
      r.fill_lw  <= 2'h0;
      r.ack      <= 1'b0;
      r.data     <= '0;
      r.mem_req  <= 1'b0;
      r.mem_addr <= '0;
    end else if (CLK_EN) begin
      r <= next_r;
    end
  end

  assign FETCH_ACK  = r.ack;
  assign FETCH_DATA = r.data;
  assign MEM_REQ    = r.mem_req;
  assign MEM_ADDR   = r.mem_addr;

  // assertions
  hit_no_mem_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && r.state == ST_IDLE && FETCH_REQ && !FLUSH && hit |=> !MEM_REQ && FETCH_ACK)
    else $error("hit started a memory fetch");
  miss_req_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && r.state == ST_IDLE && FETCH_REQ && !FLUSH && !hit |=> MEM_REQ && !FETCH_ACK)
    else $error("miss did not request memory");
  flush_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && FLUSH |=> r.valid == '0 && !MEM_REQ)
    else $error("flush left valid data");
  reset_clear_a: assert property (@(posedge REF_CLK)
    SYS_RST |=> r.valid == '0)
    else $error("reset left valid data");
  lru_victim_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && r.state == ST_IDLE && FETCH_REQ && !FLUSH && !tag_hit
    |=> r.fill_seg == $past(r.lru[SEG_CNT-1]))
    else $error("victim is not least recently used");
  lru_top_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && r.state == ST_IDLE && FETCH_REQ && !FLUSH && hit |=> r.lru[0] == $past(hit_seg))
    else $error("used segment not on top of stack");
  fill_addr_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && r.state == ST_IDLE && FETCH_REQ && !FLUSH && !hit
    |=> MEM_ADDR == {$past(FETCH_ADDR[ADDR_W-1:SUB_LSB]), 2'h0})
    else $error("fill address wrong");
  fill_valid_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && !FLUSH && r.state == ST_FILL && MEM_ACK && r.fill_lw == LW_LAST
    |=> r.valid[$past(r.fill_seg)][$past(f_sub)] && !MEM_REQ)
    else $error("completed subsegment not valid");
endmodule
`default_nettype wire

/* File: isc_mem_model.sv */
// memory controller model answering subsegment fills
`timescale 1ns/100ps
`default_nettype none
module isc_mem_model
  import isc_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // fill port
  input  wire logic                        mem_req,
  input  wire logic [isc_pkg::LW_ADDR_W-1:0] mem_addr,
  output logic                             mem_ack,
  output logic [isc_pkg::DATA_W-1:0]       mem_data,
  // bench control and tally
  input  wire logic [3:0]                  delay,
  output logic [15:0]                      words
);
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_data <= 32'h0;
      cnt <= 4'h0;
      words <= 16'h0;
    end else begin
      words <= words + ((mem_req && mem_ack) ? 16'h1 : 16'h0);
      if (mem_ack || !mem_req) begin
        mem_ack <= 1'b0;
        // idle bus never repeats the last word, so a stray take shows up
        mem_data <= ~mem_data;
        cnt <= 4'h0;
      end else if (cnt == delay) begin
        mem_ack <= 1'b1;
        mem_data <= {~mem_addr[15:0], mem_addr[15:0]};
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: isc_cache_tb.sv */
// self-checking bench for the instruction segment cache
`timescale 1ns/100ps
`default_nettype none
module isc_cache_tb;
  import isc_pkg::*;
  logic              REF_CLK = 1'b0;
  logic              SYS_RST = 1'b1;
  logic              CLK_EN = 1'b1;
  logic              FLUSH = 1'b0;
  logic              FETCH_REQ = 1'b0;
  logic [ADDR_W-1:0] FETCH_ADDR = 32'h0;
  logic              FETCH_ACK;
  logic [INSN_W-1:0] FETCH_DATA;
  logic              MEM_REQ;
  logic [26:0]       MEM_ADDR;
  logic              MEM_ACK;
  logic [DATA_W-1:0] MEM_DATA;
  logic [3:0]        delay = 4'h0;
  logic [15:0]       words;
  int                errors = 0;
  int                num_checks = 0;
  always #2.5 REF_CLK = ~REF_CLK;
  isc_cache dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .FLUSH(FLUSH),
    .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .FETCH_ACK(FETCH_ACK),
    .FETCH_DATA(FETCH_DATA), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
    .MEM_ACK(MEM_ACK), .MEM_DATA(MEM_DATA));
  isc_mem_model mem (.clk(REF_CLK), .rst(SYS_RST), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR),
    .mem_ack(MEM_ACK), .mem_data(MEM_DATA), .delay(delay), .words(words));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one fetch; fills is the number of subsegment loads it should cost
  task automatic fetch(input logic [31:0] a, input logic [15:0] fills);
    logic [15:0] w0;
    logic [26:0] la;
    int          n;
    w0 = words;
    la = a[31:5];
    n = 0;
    FETCH_REQ <= 1'b1;
    FETCH_ADDR <= a;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (FETCH_ACK !== 1'b1 && n < 300);
    FETCH_REQ <= 1'b0;
    check("ack", {31'h0, FETCH_ACK}, 32'h1);
    check("insn", {16'h0, FETCH_DATA}, {16'h0, a[4] ? ~la[15:0] : la[15:0]});
    check("fill words", {16'h0, words - w0}, {16'h0, fills * 16'h4});
    @(posedge REF_CLK);
    check("ack pulse", {31'h0, FETCH_ACK}, 32'h0);
    @(posedge REF_CLK);
  endtask
  task automatic t_reset;
    check("reset fetch", {15'h0, FETCH_ACK, FETCH_DATA}, 32'h0);
    check("reset mem", {4'h0, MEM_REQ, MEM_ADDR}, 32'h0);
  endtask
  task automatic t_hold;
    // enable low: a pending hit must wait and nothing may move
    CLK_EN <= 1'b0;
    FETCH_REQ <= 1'b1;
    FETCH_ADDR <= 32'h0000_1238;
    repeat (4) @(posedge REF_CLK);
    check("frozen", {30'h0, FETCH_ACK, MEM_REQ}, 32'h0);
    CLK_EN <= 1'b1;
    FETCH_REQ <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    fetch(32'h0000_1238, 16'h0);
  endtask
  task automatic t_rst_mid;
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    check("reset again", {15'h0, FETCH_ACK, FETCH_DATA}, 32'h0);
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
    fetch(32'h0000_1238, 16'h1);
  endtask
  task automatic t_fill_hit;
    fetch(32'h0000_1238, 16'h1);
    fetch(32'h0000_1228, 16'h0);
    fetch(32'h0000_1278, 16'h0);
    fetch(32'h0000_12B8, 16'h1);
    fetch(32'h0000_1238, 16'h0);
  endtask
  task automatic t_lru;
    fetch(32'h0001_0000, 16'h1);
    fetch(32'h0002_0000, 16'h1);
    fetch(32'h0003_0000, 16'h1);
    fetch(32'h0000_1238, 16'h0);
    fetch(32'h0004_0000, 16'h1);
    fetch(32'h0000_1238, 16'h0);
    fetch(32'h0002_0010, 16'h0);
    fetch(32'h0001_0000, 16'h1);
  endtask
  task automatic t_flush;
    int n;
    n = 0;
    delay <= 4'h3;
    FETCH_REQ <= 1'b1;
    FETCH_ADDR <= 32'h0005_0000;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (MEM_REQ !== 1'b1 && n < 50);
    check("fill start", {31'h0, MEM_REQ}, 32'h1);
    // flush lands while the fill is still waiting on slow memory
    FLUSH <= 1'b1;
    FETCH_REQ <= 1'b0;
    @(posedge REF_CLK);
    FLUSH <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    fetch(32'h0005_0000, 16'h1);
    fetch(32'h0000_1238, 16'h1);
  endtask
  task automatic complete_run;
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(100000);
    errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge REF_CLK);
    t_reset;
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
    t_fill_hit;
    t_lru;
    t_flush;
    t_hold;
    t_rst_mid;
    complete_run;
  end
endmodule
`default_nettype wire
